// >>> core/atp_top.sv
`timescale 1ns/1ns
`default_nettype none
module atp_top #(parameter int WORD_W = atp_pkg::WORD_W) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Serial control port
    input wire logic spi_sen_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_out,
    // Converter core samples
    input wire logic [WORD_W-1:0] conv_a_in,
    input wire logic [WORD_W-1:0] conv_b_in,
    input wire logic conv_valid_in,
    // Down_converter samples
    input wire logic [WORD_W-1:0] dc_a_in,
    input wire logic [WORD_W-1:0] dc_b_in,
    input wire logic dc_valid_in,
    output logic sample_ready_out,
    // Parallel output
    output logic [WORD_W-1:0] par_a_out,
    output logic [WORD_W-1:0] par_b_out,
    output logic par_valid_out,
    // Serial link
    input wire logic bit_clock_input_in,
    output logic bit_clock_input_buffer_enable_out,
    output logic serial_a_out,
    output logic serial_b_out,
    output logic shared_pin_out
);
    import atp_pkg::*;
    atp_link_if #(.WORD_W(WORD_W)) lnk ();
    // Synchronisers for the control pins and the link acknowledge
    logic sen_s1, sen_s2, sclk_s1, sclk_s2, sclk_q, sdio_s1, sdio_s2;
    logic ack_s1, ack_s2;
    always_ff @(posedge core_clk_in)
    begin
        sen_s1 <= spi_sen_n_in;
        sen_s2 <= sen_s1;
        sclk_s1 <= spi_sclk_in;
        sclk_s2 <= sclk_s1;
        sclk_q <= sclk_s2;
        sdio_s1 <= spi_sdio_in;
        sdio_s2 <= sdio_s1;
        ack_s1 <= lnk.ack;
        ack_s2 <= ack_s1;
    end
    // Serial control port slave; sclk must stay well below core clock / 4
    logic spi_sel, sclk_rise, sclk_fall;
    logic [4:0] bit_cnt;
    logic [14:0] sh_in;
    logic [7:0] rd_sh, rd_data;
    logic rd_mode, sdio_out, sdio_oe;
    logic wr_en;
    logic [6:0] wr_addr, rd_addr;
    logic [7:0] wr_data;
    assign spi_sel = ~sen_s2;
    assign sclk_rise = sclk_s2 & ~sclk_q;
    assign sclk_fall = ~sclk_s2 & sclk_q;
    assign rd_addr = {sh_in[5:0], sdio_s2};
    assign wr_en = spi_sel & sclk_rise & (bit_cnt == SPI_FRAME_BITS - 5'h01) & ~sh_in[14];
    assign wr_addr = sh_in[13:7];
    assign wr_data = {sh_in[6:0], sdio_s2};
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || !spi_sel)
        begin
            bit_cnt <= 5'h00;
            rd_mode <= 1'b0;
            sdio_oe <= 1'b0;
            sdio_out <= 1'b0;
            if (rst_in)
            begin
                sh_in <= 15'h0000;
                rd_sh <= 8'h00;
            end
        end
        else
        begin
            if (sclk_rise && bit_cnt < SPI_FRAME_BITS)
            begin
                sh_in <= {sh_in[13:0], sdio_s2};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == SPI_HDR_BITS - 5'h01)
                begin
                    rd_mode <= sh_in[6];
                    rd_sh <= rd_data;
                end
            end
            if (sclk_fall && rd_mode && bit_cnt >= SPI_HDR_BITS && bit_cnt < SPI_FRAME_BITS)
            begin
                sdio_out <= rd_sh[7];
                rd_sh <= {rd_sh[6:0], 1'b0};
                sdio_oe <= 1'b1;
            end
        end
    end
    assign spi_sdio_out = sdio_out;
    assign spi_sdio_oe_out = sdio_oe;
    // Register file
    logic [7:0] pat_low, pat_mid, pat_high, bclk_en, frame_clock_cfg, res_map;
    logic bclk_en2;
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            pat_low <= REG_RESET;
            pat_mid <= REG_RESET;
            pat_high <= REG_RESET;
            bclk_en <= REG_RESET;
            frame_clock_cfg <= REG_RESET;
            res_map <= REG_RESET;
            bclk_en2 <= 1'b0;
        end
        else if (wr_en)
        begin
            if (wr_addr == REG_PAT_LOW)
                pat_low <= wr_data;
            if (wr_addr == REG_PAT_MID)
                pat_mid <= wr_data;
            if (wr_addr == REG_PAT_HIGH)
                pat_high <= wr_data;
            if (wr_addr == REG_BCLK_EN)
                bclk_en <= wr_data;
            if (wr_addr == REG_FRAME_CLOCK_CFG)
                frame_clock_cfg <= wr_data;
            if (wr_addr == REG_RES_MAP)
                res_map <= wr_data;
            if (wr_addr == REG_BCLK_EN2)
                bclk_en2 <= wr_data[BCLK_EN2_BIT];
        end
    end
    // Only bit 6 of the shared 0x1F register lives here
    logic [7:0] bclk_en2_rd;
    assign bclk_en2_rd = {1'b0, bclk_en2, 6'h00};
    assign rd_data = (rd_addr == REG_PAT_LOW) ? pat_low
                   : (rd_addr == REG_PAT_MID) ? pat_mid
                   : (rd_addr == REG_PAT_HIGH) ? pat_high
                   : (rd_addr == REG_BCLK_EN) ? bclk_en
                   : (rd_addr == REG_FRAME_CLOCK_CFG) ? frame_clock_cfg
                   : (rd_addr == REG_RES_MAP) ? res_map
                   : (rd_addr == REG_BCLK_EN2) ? bclk_en2_rd
                   : 8'h00;
    // Decoded fields
    logic [17:0] user_pattern_value;
    logic [2:0] chan_a_pattern_select, chan_b_pattern_select;
    logic frame_clock_source, frame_clock_divide, frame_clock_output_enable;
    logic frame_clock_stretch, twenty_bit_output_enable;
    logic [2:0] mapped_resolution_select;
    assign user_pattern_value = {pat_high[1:0], pat_mid, pat_low};
    assign chan_b_pattern_select = pat_high[SEL_B_LSB +: 3];
    assign chan_a_pattern_select = pat_high[SEL_A_LSB +: 3];
    assign frame_clock_source = frame_clock_cfg[FC_SRC_BIT];
    assign frame_clock_divide = frame_clock_cfg[FC_DIV_BIT];
    assign frame_clock_output_enable = frame_clock_cfg[FC_EN_BIT];
    assign frame_clock_stretch = frame_clock_cfg[FC_STR_BIT];
    assign mapped_resolution_select = res_map[RES_LSB +: 3];
    // Decoded but not passed to the link; this block's word stays 18 bits wide
    assign twenty_bit_output_enable = res_map[TWENTY_BIT];
    // Power of the link clock buffer; the link keeps running from bit_clock_input_in while it is off
    assign bit_clock_input_buffer_enable_out = bclk_en[BCLK_EN_BIT] & bclk_en2;
    // Sample source and handshake
    logic src_valid, idle, take, req, par_valid;
    assign src_valid = frame_clock_source ? dc_valid_in : conv_valid_in;
    assign idle = (ack_s2 == req);
    assign take = src_valid & idle;
    assign sample_ready_out = idle;
    // Per-channel pattern insertion ahead of the mapper
    logic [WORD_W-1:0] src_word [2];
    logic [WORD_W-1:0] ramp [2];
    logic [WORD_W-1:0] next_word [2];
    logic [WORD_W-1:0] out_word [2];
    logic [2:0] sel [2];
    assign src_word[0] = frame_clock_source ? dc_a_in : conv_a_in;
    assign src_word[1] = frame_clock_source ? dc_b_in : conv_b_in;
    assign sel[0] = chan_a_pattern_select;
    assign sel[1] = chan_b_pattern_select;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            assign next_word[ch] = (sel[ch] == SEL_CONST) ? WORD_W'(user_pattern_value)
                                 : (sel[ch] == SEL_RAMP) ? ramp[ch]
                                 : src_word[ch];
            always_ff @(posedge core_clk_in)
            begin
                if (rst_in)
                begin
                    ramp[ch] <= '0;
                    out_word[ch] <= '0;
                end
                else
                begin
                    // Ramp restarts from zero whenever it is not selected
                    if (sel[ch] != SEL_RAMP)
                        ramp[ch] <= '0;
                    else if (take)
                        ramp[ch] <= ramp[ch] + WORD_W'(user_pattern_value);
                    if (take)
                        out_word[ch] <= next_word[ch];
                end
            end
        end
    endgenerate
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            req <= 1'b0;
            par_valid <= 1'b0;
        end
        else
        begin
            par_valid <= take;
            if (take)
                req <= ~req;
        end
    end
    // Same words feed the parallel port and the serializer
    assign par_a_out = out_word[0];
    assign par_b_out = out_word[1];
    assign par_valid_out = par_valid;
    assign lnk.word_a = out_word[0];
    assign lnk.word_b = out_word[1];
    assign lnk.req = req;
    assign lnk.fc_en = frame_clock_output_enable;
    assign lnk.fc_div = frame_clock_divide;
    assign lnk.fc_str = frame_clock_stretch;
    assign lnk.res = mapped_resolution_select;
    atp_frame_gen #(.WORD_W(WORD_W)) u_frame_gen (
        .link_clk_in(bit_clock_input_in),
        .rst_in(rst_in),
        .lnk(lnk.link)
    );
    assign serial_a_out = lnk.ser_a;
    assign serial_b_out = lnk.ser_b;
    assign shared_pin_out = lnk.shared_pin;
endmodule
`default_nettype wire

// >>> core/atp_pkg.sv
// Function
// - Constant mode outputs 18-bit pattern, MSB aligned
// - Ramp mode uses pattern as step
// - Bits 7-5 select channel B source
// - Bits 4-2 select channel A independently
// - Pattern inserted before mapper, MSB aligned
// - Patterns identical in parallel and serial formats
// - Bit clock buffer needs both enables
// - Source bit picks core or down_converter
// - Enable puts frame clock on shared pin
// - Stretch spans frame clock over A and B
// - Resolution codes select 18/16/14 bits
`default_nettype none
package atp_pkg;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 7;
    // Register offsets
    localparam logic [6:0] REG_PAT_LOW = 7'h14;
    localparam logic [6:0] REG_PAT_MID = 7'h15;
    localparam logic [6:0] REG_PAT_HIGH = 7'h16;
    localparam logic [6:0] REG_BCLK_EN = 7'h18;
    localparam logic [6:0] REG_FRAME_CLOCK_CFG = 7'h19;
    localparam logic [6:0] REG_RES_MAP = 7'h1B;
    localparam logic [6:0] REG_BCLK_EN2 = 7'h1F;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int SEL_B_LSB = 5;
    localparam int SEL_A_LSB = 2;
    localparam int BCLK_EN_BIT = 4;
    localparam int BCLK_EN2_BIT = 6;
    localparam int FC_SRC_BIT = 7;
    localparam int FC_DIV_BIT = 4;
    localparam int FC_EN_BIT = 1;
    localparam int FC_STR_BIT = 0;
    localparam int RES_LSB = 3;
    localparam int TWENTY_BIT = 6;
    // Pattern selector codes
    localparam logic [2:0] SEL_NORMAL = 3'h0;
    localparam logic [2:0] SEL_RAMP = 3'h2;
    localparam logic [2:0] SEL_CONST = 3'h3;
    // Resolution codes and word lengths
    localparam logic [2:0] RES_18 = 3'h0;
    localparam logic [2:0] RES_16 = 3'h1;
    localparam logic [2:0] RES_14 = 3'h2;
    localparam logic [5:0] LEN_18 = 6'h12;
    localparam logic [5:0] LEN_16 = 6'h10;
    localparam logic [5:0] LEN_14 = 6'h0E;
    // Serial control frame: rw, 7-bit address, 8-bit data
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    localparam logic [4:0] SPI_HDR_BITS = 5'h08;
endpackage
`default_nettype wire

// >>> core/atp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface atp_link_if #(parameter int WORD_W = atp_pkg::WORD_W);
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;
    logic req;
    logic ack;
    logic fc_en;
    logic fc_div;
    logic fc_str;
    logic [2:0] res;
    logic ser_a;
    logic ser_b;
    logic shared_pin;
    modport core (
        output word_a, word_b, req, fc_en, fc_div, fc_str, res,
        input ack, ser_a, ser_b, shared_pin
    );
    modport link (
        input word_a, word_b, req, fc_en, fc_div, fc_str, res,
        output ack, ser_a, ser_b, shared_pin
    );
endinterface
`default_nettype wire

// >>> core/atp_frame_gen.sv
`timescale 1ns/1ns
`default_nettype none
module atp_frame_gen #(parameter int WORD_W = atp_pkg::WORD_W) (
    // Link clock and core reset level
    input wire logic link_clk_in,
    input wire logic rst_in,
    // Core side
    atp_link_if.link lnk
);
    import atp_pkg::*;
    logic rst_s1, rst_s2;
    logic req_s1, req_s2, req_q;
    logic [5:0] cfg_s1, cfg_s2;
    logic [WORD_W-1:0] sh_a, sh_b;
    logic [5:0] cnt;
    logic busy, phase, ack, ser_a, ser_b, shared, par_bit;
    logic fc_en, fc_div, fc_str;
    logic [2:0] res;
    logic [5:0] len, total;
    logic new_word, last, next_frame_clock;
    assign {fc_en, fc_div, fc_str, res} = cfg_s2;
    assign new_word = req_s2 != req_q;
    assign len = (res == RES_16) ? LEN_16 : (res == RES_14) ? LEN_14 : LEN_18;
    assign total = fc_str ? {len[4:0], 1'b0} : len;
    assign last = busy && (cnt == total - 6'h01);
    // Stretch keeps it high over the whole A word, low over B
    assign next_frame_clock = !busy ? (fc_div & phase)
                     : fc_str ? (cnt < len)
                     : fc_div ? phase
                     : (cnt < {1'b0, len[5:1]});
    always_ff @(posedge link_clk_in)
    begin
        rst_s1 <= rst_in;
        rst_s2 <= rst_s1;
        req_s1 <= lnk.req;
        req_s2 <= req_s1;
        // Config is quasi-static; bits are changed only while idle
        cfg_s1 <= {lnk.fc_en, lnk.fc_div, lnk.fc_str, lnk.res};
        cfg_s2 <= cfg_s1;
    end
    always_ff @(posedge link_clk_in)
    begin
        if (rst_s2)
        begin
            req_q <= 1'b0;
            sh_a <= '0;
            sh_b <= '0;
            cnt <= 6'h00;
            busy <= 1'b0;
            phase <= 1'b0;
            ack <= 1'b0;
            ser_a <= 1'b0;
            ser_b <= 1'b0;
            shared <= 1'b0;
            par_bit <= 1'b0;
        end
        else
        begin
            req_q <= req_s2;
            shared <= fc_en ? next_frame_clock : par_bit;
            if (new_word && !busy)
            begin
                // Core holds both words stable until ack toggles back
                sh_a <= lnk.word_a;
                sh_b <= lnk.word_b;
                par_bit <= lnk.word_a[0];
                cnt <= 6'h00;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                ser_a <= sh_a[WORD_W-1];
                ser_b <= fc_str ? 1'b0 : sh_b[WORD_W-1];
                sh_a <= (fc_str && cnt == len - 6'h01) ? sh_b : {sh_a[WORD_W-2:0], 1'b0};
                // In stretch mode B must wait whole until A has gone out
                sh_b <= fc_str ? sh_b : {sh_b[WORD_W-2:0], 1'b0};
                cnt <= cnt + 6'h01;
                if (last)
                begin
                    busy <= 1'b0;
                    ack <= req_s2;
                    phase <= ~phase;
                end
            end
            else
            begin
                ser_a <= 1'b0;
                ser_b <= 1'b0;
            end
        end
    end
    assign lnk.ack = ack;
    assign lnk.ser_a = ser_a;
    assign lnk.ser_b = ser_b;
    assign lnk.shared_pin = shared;
endmodule
`default_nettype wire

// >>> sim/atp_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module atp_top_properties #(parameter int WORD_W = atp_pkg::WORD_W) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Watched ports
    input wire logic spi_sen_n_in,
    input wire logic spi_sdio_oe_out,
    input wire logic conv_valid_in,
    input wire logic dc_valid_in,
    input wire logic sample_ready_out,
    input wire logic [WORD_W-1:0] par_a_out,
    input wire logic [WORD_W-1:0] par_b_out,
    input wire logic par_valid_out,
    input wire logic bit_clock_input_buffer_enable_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // Both valids high so the take does not hinge on the source bit
    sequence s_take;
        sample_ready_out && conv_valid_in && dc_valid_in;
    endsequence
    // The link needs several core cycles to shift a word out
    sequence s_busy;
        !sample_ready_out [*2];
    endsequence
    AST_TAKE: assert property (s_take |=> par_valid_out)
        else $error("taken sample gave no output");
    AST_PULSE: assert property (par_valid_out |=> !par_valid_out)
        else $error("output valid longer than one cycle");
    AST_BUSY: assert property (par_valid_out |-> s_busy)
        else $error("ready returned before the word was sent");
    AST_BACK: assert property (par_valid_out |-> ##[1:40] sample_ready_out)
        else $error("ready did not return");
    AST_HOLD: assert property (!sample_ready_out |=> $stable(par_a_out) && $stable(par_b_out))
        else $error("output words changed without a take");
    AST_IDLE: assert property (!conv_valid_in && !dc_valid_in |=> !par_valid_out)
        else $error("output valid without any input valid");
    AST_RST: assert property ($past(rst_in) |-> !bit_clock_input_buffer_enable_out
        && !par_valid_out && !spi_sdio_oe_out)
        else $error("outputs not cleared by reset");
    AST_OE_SEL: assert property ($rose(spi_sdio_oe_out) |-> !spi_sen_n_in)
        else $error("read data driven while not selected");
    AST_OE_IDLE: assert property (spi_sen_n_in [*6] |-> !spi_sdio_oe_out)
        else $error("read driver left on after deselect");
endmodule
bind atp_top atp_top_properties #(.WORD_W(WORD_W)) i_props (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .spi_sen_n_in(spi_sen_n_in),
    .spi_sdio_oe_out(spi_sdio_oe_out),
    .conv_valid_in(conv_valid_in),
    .dc_valid_in(dc_valid_in),
    .sample_ready_out(sample_ready_out),
    .par_a_out(par_a_out),
    .par_b_out(par_b_out),
    .par_valid_out(par_valid_out),
    .bit_clock_input_buffer_enable_out(bit_clock_input_buffer_enable_out)
);
`default_nettype wire

// >>> sim/atp_capture_model.sv
`timescale 1ns/1ns
`default_nettype none
module atp_capture_model (
    // Link clock and lines from the device
    input wire logic link_clk_in,
    input wire logic serial_in,
    input wire logic frame_in,
    input wire logic [5:0] len_in,
    // Captured word and frame clock high time
    output logic [35:0] word_out,
    output logic [5:0] high_out
);
    logic frame_q = 1'b0;
    logic [5:0] bit_cnt = 6'h00;
    logic [5:0] high_cnt = 6'h00;
    // Word starts at the rising frame clock, MSB first
    always @(posedge link_clk_in)
    begin
        frame_q <= frame_in;
        if (frame_in && !frame_q)
        begin
            word_out <= {35'h0, serial_in};
            bit_cnt <= 6'h01;
            high_cnt <= 6'h01;
        end
        else
        begin
            if (bit_cnt != 6'h00 && bit_cnt < len_in)
            begin
                word_out <= {word_out[34:0], serial_in};
                bit_cnt <= bit_cnt + 6'h01;
            end
            if (frame_in)
                high_cnt <= high_cnt + 6'h01;
            else if (frame_q)
                high_out <= high_cnt;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import atp_pkg::*;
    logic core_clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic rst_in = 1'b1;
    logic sen_n = 1'b1;
    logic sclk = 1'b0;
    logic host_sdio = 1'b0;
    logic valid = 1'b0;
    logic [WORD_W-1:0] conv_a = 18'h0, conv_b = 18'h0, dc_a = 18'h0, dc_b = 18'h0;
    logic [WORD_W-1:0] par_a, par_b;
    logic sdio_out, sdio_oe, ready, par_valid, buf_en, ser_a, ser_b, shared;
    logic [5:0] cap_len = LEN_18;
    logic [35:0] cap_word;
    logic [35:0] cap_word_b;
    logic [5:0] cap_hi;
    wire logic sdio_w;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    assign sdio_w = sdio_oe ? sdio_out : host_sdio;
    initial forever #50 core_clk_in = ~core_clk_in;
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    atp_top i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .spi_sen_n_in(sen_n),
        .spi_sclk_in(sclk), .spi_sdio_in(sdio_w), .spi_sdio_out(sdio_out),
        .spi_sdio_oe_out(sdio_oe), .conv_a_in(conv_a), .conv_b_in(conv_b),
        .conv_valid_in(valid), .dc_a_in(dc_a), .dc_b_in(dc_b), .dc_valid_in(valid),
        .sample_ready_out(ready), .par_a_out(par_a), .par_b_out(par_b),
        .par_valid_out(par_valid), .bit_clock_input_in(link_clk),
        .bit_clock_input_buffer_enable_out(buf_en), .serial_a_out(ser_a),
        .serial_b_out(ser_b), .shared_pin_out(shared));
    atp_capture_model i_rx (.link_clk_in(link_clk), .serial_in(ser_a), .frame_in(shared),
        .len_in(cap_len), .word_out(cap_word), .high_out(cap_hi));
    atp_capture_model i_rx_b (.link_clk_in(link_clk), .serial_in(ser_b), .frame_in(shared),
        .len_in(cap_len), .word_out(cap_word_b), .high_out());
    task automatic check_val(input string name, input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge core_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            complete_run();
        end
    end
    // Slow serial clock: the port sees it through a synchronizer
    task automatic spi_xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [15:0] frame;
        frame = {rd, a, d};
        q = 8'h00;
        @(posedge core_clk_in) sen_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge core_clk_in) sclk <= 1'b0;
            host_sdio <= frame[i];
            repeat (6) @(posedge core_clk_in);
            if (i < 8)
                q[i] = sdio_w;
            sclk <= 1'b1;
            repeat (4) @(posedge core_clk_in);
        end
        sclk <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        sen_n <= 1'b1;
        repeat (8) @(posedge core_clk_in);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi_xfer(1'b0, a, d, q);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        spi_xfer(1'b1, a, 8'h00, q);
        check_val("register", {28'h0, exp}, {28'h0, q});
    endtask
    task automatic wait_ready;
        @(negedge core_clk_in);
        for (int n = 0; n < 60 && ready !== 1'b1; n++)
            @(negedge core_clk_in);
        check_bit("ready", 1'b1, ready);
        repeat (2) @(posedge core_clk_in);
    endtask
    // Offers one sample pair and judges the parallel words
    task automatic sample(input logic [17:0] ca, cb, da, db, ea, eb);
        wait_ready();
        conv_a <= ca;
        conv_b <= cb;
        dc_a <= da;
        dc_b <= db;
        valid <= 1'b1;
        @(posedge core_clk_in);
        valid <= 1'b0;
        @(negedge core_clk_in);
        check_bit("par_valid", 1'b1, par_valid);
        check_val("par_a", {18'h0, ea}, {18'h0, par_a});
        check_val("par_b", {18'h0, eb}, {18'h0, par_b});
    endtask
    task automatic test_regs;
        logic [6:0] regs[6] = '{REG_PAT_LOW, REG_PAT_MID, REG_PAT_HIGH, REG_BCLK_EN,
            REG_FRAME_CLOCK_CFG, REG_RES_MAP};
        foreach (regs[i])
            rd_chk(regs[i], REG_RESET);
        rd_chk(7'h30, 8'h00);
        wr(REG_RES_MAP, 8'h10);
        rd_chk(REG_RES_MAP, 8'h10);
    endtask
    task automatic test_select;
        wr(REG_PAT_LOW, 8'h34);
        wr(REG_PAT_MID, 8'h12);
        wr(REG_PAT_HIGH, 8'h62);
        sample(18'h0ABCD, 18'h11111, 18'h3FFFF, 18'h3FFFF, 18'h0ABCD, 18'h21234);
        wr(REG_PAT_HIGH, 8'h0E);
        sample(18'h0ABCD, 18'h11111, 18'h3FFFF, 18'h3FFFF, 18'h21234, 18'h11111);
        wr(REG_PAT_HIGH, 8'h26);
        sample(18'h0ABCD, 18'h11111, 18'h3FFFF, 18'h3FFFF, 18'h0ABCD, 18'h11111);
    endtask
    task automatic test_ramp;
        wr(REG_PAT_LOW, 8'h00);
        wr(REG_PAT_MID, 8'h00);
        wr(REG_PAT_HIGH, 8'h4B);
        sample(18'h1, 18'h2, 18'h3, 18'h4, 18'h00000, 18'h00000);
        sample(18'h1, 18'h2, 18'h3, 18'h4, 18'h30000, 18'h30000);
        sample(18'h1, 18'h2, 18'h3, 18'h4, 18'h20000, 18'h20000);
        wr(REG_PAT_LOW, 8'h04);
        wr(REG_PAT_HIGH, 8'h48);
        sample(18'h1, 18'h2, 18'h3, 18'h4, 18'h10000, 18'h10000);
        sample(18'h1, 18'h2, 18'h3, 18'h4, 18'h10004, 18'h10004);
    endtask
    task automatic test_source;
        wr(REG_PAT_HIGH, 8'h00);
        wr(REG_FRAME_CLOCK_CFG, 8'h80);
        sample(18'h00001, 18'h00002, 18'h00003, 18'h00004, 18'h00003, 18'h00004);
        wait_ready();
        check_bit("shared pin", 1'b1, shared);
        wr(REG_FRAME_CLOCK_CFG, 8'h00);
        sample(18'h00001, 18'h00002, 18'h00003, 18'h00004, 18'h00001, 18'h00002);
    endtask
    task automatic test_frame;
        logic lvl;
        cap_len <= LEN_14;
        wr(REG_PAT_LOW, 8'hC3);
        wr(REG_PAT_MID, 8'hA5);
        wr(REG_PAT_HIGH, 8'h0E);
        wr(REG_FRAME_CLOCK_CFG, 8'h02);
        sample(18'h00000, 18'h15A3C, 18'h0, 18'h0, 18'h2A5C3, 18'h15A3C);
        wait_ready();
        check_val("serial word", 36'h2A5C, cap_word);
        check_val("frame high", 36'h7, {30'h0, cap_hi});
        check_val("serial b word", 36'h15A3, cap_word_b);
        cap_len <= LEN_18 + LEN_18;
        wr(REG_RES_MAP, 8'h00);
        wr(REG_FRAME_CLOCK_CFG, 8'h03);
        sample(18'h00000, 18'h15A3C, 18'h0, 18'h0, 18'h2A5C3, 18'h15A3C);
        wait_ready();
        check_val("serial word", {18'h2A5C3, 18'h15A3C}, cap_word);
        check_val("frame high", 36'h12, {30'h0, cap_hi});
        check_val("serial b word", 36'h0, cap_word_b);
        wr(REG_FRAME_CLOCK_CFG, 8'h12);
        sample(18'h00000, 18'h15A3C, 18'h0, 18'h0, 18'h2A5C3, 18'h15A3C);
        wait_ready();
        lvl = shared;
        sample(18'h00000, 18'h15A3C, 18'h0, 18'h0, 18'h2A5C3, 18'h15A3C);
        wait_ready();
        check_bit("frame level", ~lvl, shared);
        wr(REG_FRAME_CLOCK_CFG, 8'h00);
    endtask
    task automatic test_bufen;
        wr(REG_BCLK_EN, 8'h10);
        check_bit("buffer enable", 1'b0, buf_en);
        wr(REG_BCLK_EN2, 8'h40);
        check_bit("buffer enable", 1'b1, buf_en);
        rd_chk(REG_BCLK_EN2, 8'h40);
        wr(REG_BCLK_EN, 8'h00);
        check_bit("buffer enable", 1'b0, buf_en);
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        test_regs();
        test_select();
        test_ramp();
        test_source();
        test_frame();
        test_bufen();
        complete_run();
    end
endmodule
`default_nettype wire
